// ### sspp_axil.v
`timescale 1ns/1ps
`include "sspp_defs.vh"

module sspp_axil (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  output wire        wr_en,
  output reg  [7:0]  wr_addr,
  output reg  [31:0] wr_data,
  output reg  [3:0]  wr_strb,
  input  wire        wr_ok,
  output wire        rd_en,
  input  wire [31:0] rd_data,
  input  wire        rd_ok
);

  reg aw_got_reg;
  reg w_got_reg;

  assign wr_en = aw_got_reg & w_got_reg & ~bvalid;
  assign rd_en = arvalid & arready;

  always @(posedge clk) begin
    if (!rst_b) begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= `SSPP_OKAY;
      wr_addr    <= 8'h00;
      wr_data    <= 32'h00000000;
      wr_strb    <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_got_reg <= 1'b1;
        awready    <= 1'b0;
        wr_addr    <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_reg <= 1'b1;
        wready    <= 1'b0;
        wr_data   <= wdata;
        wr_strb   <= wstrb;
      end
      if (wr_en) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid     <= 1'b1;
        bresp      <= wr_ok ? `SSPP_OKAY : `SSPP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `SSPP_OKAY;
    end else if (rd_en) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_ok ? rd_data : 32'h00000000;
      rresp   <= rd_ok ? `SSPP_OKAY : `SSPP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule // sspp_axil

// ### sspp_defs.vh
`ifndef SSPP_DEFS_VH
`define SSPP_DEFS_VH

// Word and pin geometry
`define SSPP_WL          8
`define SSPP_NPIN        5
`define SSPP_P_SC0       0
`define SSPP_P_SC1       1
`define SSPP_P_FS        2
`define SSPP_P_SCK       3
`define SSPP_P_RD        4

// Register index (byte address = index * 4)
`define SSPP_I_PCR       3'h0
`define SSPP_I_PRR       3'h1
`define SSPP_I_PDR       3'h2
`define SSPP_I_CTRL      3'h3
`define SSPP_I_TX1       3'h4
`define SSPP_I_TX2       3'h5
`define SSPP_I_RX        3'h6
`define SSPP_I_STAT      3'h7

// Control register fields
`define SSPP_C_EN        0
`define SSPP_C_SYNC      1
`define SSPP_C_SCKO      2
`define SSPP_C_FSO       3
`define SSPP_C_RCKO      4
`define SSPP_C_RFSO      5
`define SSPP_C_TX1SEL    6
`define SSPP_C_TX2SEL    7
`define SSPP_C_FLAG0     8
`define SSPP_C_FLAG1     9
`define SSPP_C_DIV_LSB   16
`define SSPP_C_DIV_MSB   23

// Status register fields
`define SSPP_S_TDRE      0
`define SSPP_S_RDRF      1
`define SSPP_S_ROE       2
`define SSPP_S_TUE       3

// Reset values
`define SSPP_PCR_RST     5'h00
`define SSPP_PRR_RST     5'h00
`define SSPP_PIN_RST     5'h00
`define SSPP_OEB_RST     5'h1f
`define SSPP_CTRL_RST    24'h000000

// Serial clock least period in system cycles, and cycles per half
`define SSPP_MIN_PER_HALFT 6
`define SSPP_MIN_HALF_CYC  (`SSPP_MIN_PER_HALFT / 2)
// Least divider value (half cycles minus one), at counter width
`define SSPP_HALF_FLOOR    8'h02
// Last bit index of a word, at the transmit and receive counter widths
`define SSPP_TX_LAST       3'h7
`define SSPP_RX_LAST       4'h7

// Bus answers
`define SSPP_OKAY        2'h0
`define SSPP_SLVERR      2'h2

`endif

// ### sspp_far_end.sv
`timescale 1ns/1ps
module sspp_far_end (
  input  wire logic [4:0] pin_out,
  input  wire logic [4:0] pin_oe_b,
  output logic      [4:0] pin_in
);
  logic [4:0] drv    = 5'h00;
  logic [4:0] far_en = 5'h1c;
  //////////////////////////////////////////////////////////////////////////
  // Pins 0 and 1, when undriven, show the inverse of the last level, never a lucky match; pins 2 to 4 take the far-end drive
  always_comb
    for (int i = 0; i < 5; i++)
      pin_in[i] = !pin_oe_b[i] ? pin_out[i]
                : (far_en[i] ? drv[i] : ~pin_out[i]);
  //////////////////////////////////////////////////////////////////////////
  // Bit clock runs only inside the frame, then stands low
  task automatic frame(input logic [7:0] rx_byte,
                       output logic [7:0] tx_byte);
    #1.3;
    for (int i = 7; i >= 0; i--) begin
      drv[2] = (i == 7);
      drv[4] = rx_byte[i];
      #12 drv[3] = 1'b1;
      #24 drv[3] = 1'b0; // Half period 24 ns
      #12 tx_byte[i] = pin_in[0];
    end
    drv[4] = ~drv[4];
    #48;
  endtask
endmodule // sspp_far_end

// ### sspp_port.v
`timescale 1ns/1ps
`include "sspp_defs.vh"

module sspp_port (
  input  wire                  clk,
  input  wire                  rst_b,
  input  wire                  stop_req,
  input  wire [`SSPP_NPIN-1:0] pin_in,
  output reg  [`SSPP_NPIN-1:0] pin_out,
  output reg  [`SSPP_NPIN-1:0] pin_oe_b,
  output reg  [`SSPP_NPIN-1:0] pin_keep,
  input  wire [7:0]            awaddr,
  input  wire                  awvalid,
  output wire                  awready,
  input  wire [31:0]           wdata,
  input  wire [3:0]            wstrb,
  input  wire                  wvalid,
  output wire                  wready,
  output wire [1:0]            bresp,
  output wire                  bvalid,
  input  wire                  bready,
  input  wire [7:0]            araddr,
  input  wire                  arvalid,
  output wire                  arready,
  output wire [31:0]           rdata,
  output wire [1:0]            rresp,
  output wire                  rvalid,
  input  wire                  rready
);

  localparam WL = `SSPP_WL;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  wire [`SSPP_NPIN-1:0] sin;
  wire                  wr_en;
  wire [7:0]            wr_addr;
  wire [31:0]           wr_data;
  wire [3:0]            wr_strb;
  wire                  rd_en;
  reg  [31:0]           rd_data;
  wire                  wr_ok;
  wire                  rd_ok;

  reg  [`SSPP_NPIN-1:0] pcr_reg;
  reg  [`SSPP_NPIN-1:0] prr_reg;
  reg  [`SSPP_NPIN-1:0] pdr_reg;
  reg  [23:0]           ctrl_reg;
  reg  [WL-1:0]         txh1_reg;
  reg  [WL-1:0]         txh2_reg;
  reg  [WL-1:0]         rxd_reg;
  reg                   tdre_reg;
  reg                   rdrf_reg;
  reg                   roe_reg;
  reg                   tue_reg;

  reg  [7:0]            div_cnt_reg;
  reg                   int_clk_reg;
  reg                   txclk_prev_reg;
  reg                   rxclk_prev_reg;
  reg  [2:0]            tx_cnt_reg;
  reg  [WL-1:0]         tx1_sh_reg;
  reg  [WL-1:0]         tx2_sh_reg;
  reg  [3:0]            rx_cnt_reg;
  reg  [2:0]            rx_fcnt_reg;
  reg  [WL-1:0]         rx_sh_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register index decode, shared by the write and read paths
  function [3:0] reg_index;
    input [7:0] addr;
    begin
      reg_index = {(addr[7:5] == 3'h0 && addr[1:0] == 2'h0), addr[4:2]};
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer      k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and bus slave
  sspp_sync #(
    .W (`SSPP_NPIN)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (pin_in),
    .q     (sin)
  );

  sspp_axil u_axil (
    .clk     (clk),
    .rst_b   (rst_b),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_en   (rd_en),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  wire [3:0] widx = reg_index(wr_addr);
  wire [3:0] ridx = reg_index(araddr);
  assign wr_ok = widx[3];
  assign rd_ok = ridx[3];
  wire       wr_go = wr_en & wr_ok;
  wire [31:0] wm   = merge(32'h00000000, wr_data, wr_strb);
  wire [31:0] cm   = merge({8'h00, ctrl_reg}, wr_data, wr_strb);

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode and clock/frame selection
  wire en    = ctrl_reg[`SSPP_C_EN];
  wire syn   = ctrl_reg[`SSPP_C_SYNC];
  wire scko  = ctrl_reg[`SSPP_C_SCKO];
  wire fso   = ctrl_reg[`SSPP_C_FSO];
  wire rcko  = ctrl_reg[`SSPP_C_RCKO];
  wire rfso  = ctrl_reg[`SSPP_C_RFSO];
  wire run   = en & ~stop_req;
  wire [7:0] div = ctrl_reg[`SSPP_C_DIV_MSB:`SSPP_C_DIV_LSB];
  // Internal clock never faster than the sampling limit allows
  wire [7:0] half_lim = (div < `SSPP_HALF_FLOOR) ?
                        `SSPP_HALF_FLOOR : div;

  wire fs_int    = en & (tx_cnt_reg == 3'h0);
  wire rx_fs_int = syn ? fs_int : (rx_fcnt_reg == 3'h0);
  wire tx_clk_l  = scko ? int_clk_reg : sin[`SSPP_P_SCK];
  wire tx_fs_l   = fso ? fs_int : sin[`SSPP_P_FS];
  // Sync mode shares bit clock and frame sync; async uses the control pins
  wire rx_clk_l  = syn ? tx_clk_l :
                   (rcko ? int_clk_reg : sin[`SSPP_P_SC0]);
  wire rx_fs_l   = syn ? tx_fs_l :
                   (rfso ? rx_fs_int : sin[`SSPP_P_SC1]);
  wire tx_rise   = run & tx_clk_l & ~txclk_prev_reg;
  wire rx_rise   = run & rx_clk_l & ~rxclk_prev_reg;
  wire rx_fall   = run & ~rx_clk_l & rxclk_prev_reg;
  wire tx_start  = fso ? (tx_cnt_reg == `SSPP_TX_LAST) : tx_fs_l;
  wire rx_done   = rx_fall & (rx_cnt_reg == `SSPP_RX_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Bit clock generator and edge trackers
  always @(posedge clk) begin
    if (!rst_b) begin
      div_cnt_reg    <= 8'h00;
      int_clk_reg    <= 1'b0;
      txclk_prev_reg <= 1'b0;
      rxclk_prev_reg <= 1'b0;
    end else begin
      txclk_prev_reg <= tx_clk_l;
      rxclk_prev_reg <= rx_clk_l;
      if (!run) begin
        div_cnt_reg <= 8'h00;
      end else if (div_cnt_reg >= half_lim) begin
        div_cnt_reg <= 8'h00;
        int_clk_reg <= ~int_clk_reg;
      end else begin
        div_cnt_reg <= div_cnt_reg + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitters: both shift on the rising bit clock, MSB first
  always @(posedge clk) begin
    if (!rst_b) begin
      tx_cnt_reg <= `SSPP_TX_LAST;
      tx1_sh_reg <= {WL{1'b0}};
      tx2_sh_reg <= {WL{1'b0}};
    end else if (tx_rise) begin
      if (tx_start) begin
        tx_cnt_reg <= 3'h0;
        tx1_sh_reg <= tdre_reg ? {WL{1'b0}} : txh1_reg;
        tx2_sh_reg <= tdre_reg ? {WL{1'b0}} : txh2_reg;
      end else if (tx_cnt_reg != `SSPP_TX_LAST) begin
        tx_cnt_reg <= tx_cnt_reg + 3'h1;
        tx1_sh_reg <= {tx1_sh_reg[WL-2:0], 1'b0};
        tx2_sh_reg <= {tx2_sh_reg[WL-2:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: samples on the falling bit clock
  always @(posedge clk) begin
    if (!rst_b) begin
      rx_cnt_reg  <= 4'h0;
      rx_fcnt_reg <= 3'h0;
      rx_sh_reg   <= {WL{1'b0}};
      rxd_reg     <= {WL{1'b0}};
    end else begin
      if (rx_rise) begin
        rx_fcnt_reg <= rx_fcnt_reg + 3'h1;
      end
      if (rx_fall) begin
        rx_sh_reg <= {rx_sh_reg[WL-2:0], sin[`SSPP_P_RD]};
        if (rx_done) begin
          rxd_reg    <= {rx_sh_reg[WL-2:0], sin[`SSPP_P_RD]};
          rx_cnt_reg <= 4'h0;
        end else if (rx_fs_l) begin
          rx_cnt_reg <= 4'h1;
        end else if (rx_cnt_reg != 4'h0) begin
          rx_cnt_reg <= rx_cnt_reg + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers; hardware set wins over software clear
  wire tx1_load = tx_rise & tx_start;
  wire rx_read  = rd_en & rd_ok & (ridx[2:0] == `SSPP_I_RX);

  always @(posedge clk) begin
    if (!rst_b) begin
      pcr_reg  <= `SSPP_PCR_RST;
      prr_reg  <= `SSPP_PRR_RST;
      pdr_reg  <= `SSPP_PIN_RST;
      ctrl_reg <= `SSPP_CTRL_RST;
      txh1_reg <= {WL{1'b0}};
      txh2_reg <= {WL{1'b0}};
      tdre_reg <= 1'b1;
      rdrf_reg <= 1'b0;
      roe_reg  <= 1'b0;
      tue_reg  <= 1'b0;
    end else begin
      if (wr_go) begin
        case (widx[2:0])
          `SSPP_I_PCR:  pcr_reg  <= wm[`SSPP_NPIN-1:0];
          `SSPP_I_PRR:  prr_reg  <= wm[`SSPP_NPIN-1:0];
          `SSPP_I_PDR:  pdr_reg  <= wm[`SSPP_NPIN-1:0];
          `SSPP_I_CTRL: ctrl_reg <= cm[23:0];
          `SSPP_I_TX1:  txh1_reg <= wm[WL-1:0];
          `SSPP_I_TX2:  txh2_reg <= wm[WL-1:0];
          default:      ;
        endcase
      end
      if (tx1_load) begin
        tdre_reg <= 1'b1;
      end else if (wr_go && widx[2:0] == `SSPP_I_TX1) begin
        tdre_reg <= 1'b0;
      end
      if (tx1_load && tdre_reg) begin
        tue_reg <= 1'b1;
      end else if (wr_go && widx[2:0] == `SSPP_I_STAT &&
                   wm[`SSPP_S_TUE]) begin
        tue_reg <= 1'b0;
      end
      if (rx_done) begin
        rdrf_reg <= 1'b1;
      end else if (rx_read) begin
        rdrf_reg <= 1'b0;
      end
      if (rx_done && rdrf_reg && !rx_read) begin
        roe_reg <= 1'b1;
      end else if (wr_go && widx[2:0] == `SSPP_I_STAT &&
                   wm[`SSPP_S_ROE]) begin
        roe_reg <= 1'b0;
      end
    end
  end

  always @* begin
    case (ridx[2:0])
      `SSPP_I_PCR:  rd_data = {27'h0000000, pcr_reg};
      `SSPP_I_PRR:  rd_data = {27'h0000000, prr_reg};
      `SSPP_I_PDR:  rd_data = {27'h0000000, sin};
      `SSPP_I_CTRL: rd_data = {8'h00, ctrl_reg};
      `SSPP_I_TX1:  rd_data = {24'h000000, txh1_reg};
      `SSPP_I_TX2:  rd_data = {24'h000000, txh2_reg};
      `SSPP_I_RX:   rd_data = {24'h000000, rxd_reg};
      `SSPP_I_STAT: rd_data = {28'h0000000, tue_reg, roe_reg,
                               rdrf_reg, tdre_reg};
      default:      rd_data = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin multiplexer
  reg [`SSPP_NPIN-1:0] ser_dir;
  reg [`SSPP_NPIN-1:0] ser_val;

  always @* begin
    ser_dir = {`SSPP_NPIN{1'b0}};
    ser_val = {`SSPP_NPIN{1'b0}};
    ser_dir[`SSPP_P_SC0] = syn | rcko;
    ser_val[`SSPP_P_SC0] = syn ? (ctrl_reg[`SSPP_C_TX1SEL] ?
                           tx1_sh_reg[WL-1] : ctrl_reg[`SSPP_C_FLAG0]) :
                           int_clk_reg;
    ser_dir[`SSPP_P_SC1] = syn | rfso;
    ser_val[`SSPP_P_SC1] = syn ? (ctrl_reg[`SSPP_C_TX2SEL] ?
                           tx2_sh_reg[WL-1] : ctrl_reg[`SSPP_C_FLAG1]) :
                           rx_fs_int;
    ser_dir[`SSPP_P_FS]  = fso;
    ser_val[`SSPP_P_FS]  = fs_int;
    ser_dir[`SSPP_P_SCK] = scko;
    ser_val[`SSPP_P_SCK] = int_clk_reg;
  end

  // GPIO direction only matters on pins not handed to the serial port
  wire [`SSPP_NPIN-1:0] dir_v = (pcr_reg & ser_dir) |
                                (~pcr_reg & prr_reg);
  wire [`SSPP_NPIN-1:0] val_v = (pcr_reg & ser_val) |
                                (~pcr_reg & pdr_reg);

  // Only stop touches the drivers; a wait state has no path here
  always @(posedge clk) begin
    if (!rst_b) begin
      pin_out  <= `SSPP_PIN_RST;
      pin_oe_b <= `SSPP_OEB_RST;
      pin_keep <= `SSPP_PIN_RST;
    end else if (stop_req) begin
      pin_oe_b <= `SSPP_OEB_RST;
      pin_keep <= pin_keep | ~pin_oe_b;
    end else begin
      pin_out  <= val_v;
      pin_oe_b <= ~dir_v;
      pin_keep <= `SSPP_PIN_RST;
    end
  end

endmodule // sspp_port

// ### sspp_port_properties.sv
`timescale 1ns/1ps
module sspp_port_chk (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        stop_req,
  input wire logic [4:0]  pin_out,
  input wire logic [4:0]  pin_oe_b,
  input wire logic [4:0]  pin_keep,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////////
  // Keeper must remember the pre-stop directions, not the tri-stated ones
  sequence s_stop_entry;
    !stop_req ##1 stop_req [*3];
  endsequence
  sequence s_read_take;
    arvalid && arready;
  endsequence
  sequence s_write_take;
    awvalid && awready && wvalid && wready;
  endsequence
  //////////////////////////////////////////////////////////////////////////
  AST_RST_STATE: assert property ($rose(rst_b) |->
    pin_oe_b == 5'h1f && pin_keep == 5'h00)
    else $error("pins not all inputs after reset");
  AST_KEEP_ONLY_STOP: assert property (pin_keep != 5'h00 |->
    $past(stop_req))
    else $error("keeper active outside stop");
  AST_STOP_TRI: assert property (stop_req [*2] |->
    pin_oe_b == 5'h1f)
    else $error("driver still on in stop");
  AST_STOP_HOLD: assert property (stop_req && $past(stop_req) |->
    $stable(pin_out))
    else $error("pin level moved in stop");
  AST_KEEP_MATCH: assert property (s_stop_entry |->
    pin_keep == ~$past(pin_oe_b, 2))
    else $error("keeper set differs from former outputs");
  AST_OE_CAUSE: assert property ($changed(pin_oe_b) |->
    $past(bvalid) || $past(bvalid, 2) || $past(stop_req)
    || $past(stop_req, 2))
    else $error("direction changed with no write or stop");
  AST_READ_LAT: assert property (s_read_take |=> rvalid)
    else $error("read answer late");
  AST_READ_DONE: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read answer not retired");
  AST_WRITE_LAT: assert property (s_write_take |=> !bvalid ##1 bvalid)
    else $error("write answer not two edges after take");
endmodule // sspp_port_chk

bind sspp_port sspp_port_chk i_chk (.clk, .rst_b, .stop_req, .pin_out,
  .pin_oe_b, .pin_keep, .awvalid, .awready, .wvalid, .wready, .bvalid,
  .bready, .arvalid, .arready, .rvalid, .rready);

// ### sspp_sync.v
`timescale 1ns/1ps
`include "sspp_defs.vh"

module sspp_sync #(
  parameter W = `SSPP_NPIN
) (
  input  wire         clk,
  input  wire         rst_b,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg  [W-1:0] s1_reg;
  reg  [W-1:0] s2_reg;
  reg  [W-1:0] s3_reg;
  wire [W-1:0] agree;

  // Only the second and third stages are compared; the first is left alone
  assign agree = ~(s2_reg ^ s3_reg);

  always @(posedge clk) begin
    if (!rst_b) begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
      s3_reg <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q      <= (s3_reg & agree) | (q & ~agree);
    end
  end

endmodule // sspp_sync

// ### sync_serial_port_pins_tb.sv
`timescale 1ns/1ps
`include "sspp_defs.vh"
module sync_serial_port_pins_tb;
  logic        clk = 0, rst_b = 0, stop_req = 0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, d;
  logic [4:0]  pin_in, pin_out, pin_oe_b, pin_keep, p;
  logic [7:0]  txb;
  logic        b;
  int          err_count = 0, total_checks = 0, n;

  always #2.5 clk = ~clk;

  sspp_port i_dut (.clk(clk), .rst_b(rst_b), .stop_req(stop_req),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_b(pin_oe_b),
    .pin_keep(pin_keep), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  sspp_far_end i_far (.pin_out(pin_out), .pin_oe_b(pin_oe_b),
    .pin_in(pin_in));
  //////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask
  task automatic chk_p(input logic [4:0] got, input logic [4:0] exp);
    chk_w({27'h0, got}, {27'h0, exp});
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Both channels offered together; each dropped at its own take
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    int k;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk_w({30'h0, bresp}, {30'h0, er});
    if (k == 100) close_out();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    input logic [1:0] er);
    int k;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    rready <= 1'b0;
    chk_w({30'h0, rresp}, {30'h0, er});
    if (k == 100) close_out();
  endtask
  // Waits on direction (sel 0) or on the two control pin levels (sel 1)
  task automatic wait_for(input logic sel, input logic [4:0] exp);
    int k;
    logic [4:0] v;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      v = sel ? {3'h0, pin_out[1:0]} : pin_oe_b;
      if (v === exp) break;
    end
    chk_p(v, exp);
    if (k == 50) close_out();
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk_p(pin_oe_b, 5'h1f);
    chk_p(pin_keep, 5'h00);
    rd(8'h00, d, `SSPP_OKAY);
    chk_w(d, 32'h0);
    rd(8'h04, d, `SSPP_OKAY);
    chk_w(d, 32'h0);
    rd(8'h20, d, `SSPP_SLVERR);
    $display("test reset done");
    wr(8'h08, 32'h0a, `SSPP_OKAY);
    wr(8'h04, 32'h1f, `SSPP_OKAY);
    wait_for(1'b0, 5'h00);
    chk_p(pin_out, 5'h0a);
    rd(8'h04, d, `SSPP_OKAY);
    chk_w(d, 32'h1f);
    rd(8'h08, d, `SSPP_OKAY);
    chk_w(d, 32'h0a);
    $display("test gpio done");
    // GPIO says all outputs; serial config must override it
    wr(8'h10, 32'h3c, `SSPP_OKAY);
    wr(8'h0c, 32'hc3, `SSPP_OKAY);
    wr(8'h00, 32'h1f, `SSPP_OKAY);
    wait_for(1'b0, 5'h1c);
    i_far.frame(8'ha5, txb);
    chk_w({24'h0, txb}, 32'h3c);
    rd(8'h1c, d, `SSPP_OKAY);
    chk_w(d & 32'h2, 32'h2);
    rd(8'h18, d, `SSPP_OKAY);
    chk_w(d, 32'ha5);
    $display("test sync frame done");
    wr(8'h0c, 32'h203, `SSPP_OKAY);
    wait_for(1'b1, 5'h02);
    wr(8'h0c, 32'h103, `SSPP_OKAY);
    wait_for(1'b1, 5'h01);
    $display("test flags done");
    wr(8'h0c, 32'h2003d, `SSPP_OKAY);
    wait_for(1'b0, 5'h10);
    b = pin_out[3];
    for (n = 0; n < 20 && pin_out[3] === b; n++) @(posedge clk);
    b = pin_out[3];
    for (n = 0; n < 20 && pin_out[3] === b; n++) @(posedge clk);
    chk_w(n, 32'd3);
    $display("test async clock done");
    stop_req <= 1'b1;
    wait_for(1'b0, 5'h1f);
    @(posedge clk);
    chk_p(pin_keep, 5'h0f);
    p = pin_out;
    repeat (4) @(posedge clk);
    chk_p(pin_out, p);
    stop_req <= 1'b0;
    wait_for(1'b0, 5'h10);
    $display("test stop done");
    wr(8'h00, 32'h0, `SSPP_OKAY);
    wait_for(1'b0, 5'h00);
    wr(8'h04, 32'h0, `SSPP_OKAY);
    wait_for(1'b0, 5'h1f);
    $display("test hand back done");
    close_out();
  end
endmodule // sync_serial_port_pins_tb
